// file: include/dsr_pkg.sv
// constants and types of the display and settings register command block
package dsr_pkg;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PLOT = 8'h04;
  localparam logic [7:0] A_CMD = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_DATA = 8'h10;
  localparam logic [7:0] A_FLAG = 8'h14;
  // reset values
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [1:0] PLOTTER_SELECT_RST = 2'h0;
  localparam logic [7:0] REF_RST = 8'h80;
  // command field positions
  localparam int CMD_TYPE = 3;
  localparam int CMD_FP = 4;
  localparam int CMD_NUM = 8;
  // status field positions
  localparam int ST_ERR = 0;
  localparam int ST_NUM = 8;
  localparam int ST_BUSY = 16;
  localparam int ST_MACRO = 24;
  // error codes and answers
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_RANGE = 8'h2F;
  localparam logic [7:0] ERR_EMPTY = 8'h3E;
  localparam logic [7:0] ERR_SUM = 8'hBE;
  localparam logic [7:0] NUM_RANGE = 8'hFF;
  localparam logic [7:0] NUM_EMPTY = 8'hFE;
  localparam logic [3:0] MACRO_BYTES = 4'h2;
  // register counts and block lengths
  localparam logic [7:0] SET_MAX = 8'h09;
  localparam logic [7:0] WAV_MAX = 8'h08;
  localparam logic [9:0] SET_LEN = 10'h080;
  localparam logic [9:0] WAV_LEN = 10'h282;
  localparam logic [7:0] REF_MAX = 8'hFF;
  localparam logic [7:0] REF_VIS_LO = 8'h19;
  localparam logic [7:0] REF_VIS_HI = 8'hE1;
  // command opcodes
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_STORE = 3'h1, OP_RECALL = 3'h2,
    OP_RD_WR = 3'h3, OP_RD_RD = 3'h4, OP_HELP = 3'h5
  } op_t;
  // register data stream states
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_WR = 2'b01, S_RD = 2'b11} st_t;
  typedef struct packed {
    logic end_of_sweep_correction;
    logic baseline_blank_switch;
    logic graticule_light_switch;
    logic settings_readout_switch;
  } ctrl_t;
  typedef struct packed {
    logic a_trace_view;
    logic b_trace_view;
    logic difference_trace_view;
    logic marker_on;
    logic storage_on;
    logic macro_buffer_shown;
  } waveform_block_type_t;
  typedef struct packed {
    logic two_colour;
    logic macro_only;
    logic diff_trace;
    logic b_trace;
    logic a_trace;
    logic markers_x;
    logic bezel;
    logic scale_graticule_light_switch;
    logic settings;
  } plot_t;
endpackage

// file: rtl/dsr_cmd.sv
// display control and settings register command block with AXI4-Lite slave
// Contract
// - readout switch shows settings, resets on
// - graticule light switch, resets off
// - baseline blanking of lowest division, resets off
// - store copies settings into location 0-9
// - power-off saves settings into location zero
// - recall restores; empty location gives error 62
// - register data write; bad number error 47
// - internal checksum mismatch gives error 190
// - query payload 128 or 642 bytes
// - query number -1 or -2, zero payload
// - plot readout, scale, bezel by switches
// - plot markers as X with storage
// - plot each trace only when viewed
// - macro buffer shown plots alone
// - multi-pen: waveform in other colour
// - plotter codes 0-3, power-up last stored (code keeps reset value 0, as set_ok_q clears on reset)
// - plot reference clamps to 0-255 silently
// - end-of-sweep correction switch, resets off
// - help query plain or front-panel form
// - each command takes two macro bytes
`timescale 1ns/10ps
module dsr_cmd (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dsr_pkg::waveform_block_type_t waveform_block_type_state,
  input wire logic power_fail,
  output dsr_pkg::ctrl_t ctrl,
  output logic [1:0] plotter_select,
  output logic [7:0] difference_plot_reference,
  output dsr_pkg::plot_t plot_content,
  output logic help_req,
  output logic help_front_panel
);
  import dsr_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  ctrl_t ctrl_q, ctrl_d;
  logic [1:0] plotter_select_q, plotter_select_d;
  logic [7:0] ref_q, ref_d;
  plot_t plot_q;
  logic help_q, help_fp_q;
  logic [7:0] err_q, err_d;
  logic [7:0] rnum_q, rnum_d;
  logic init_q;
  logic [9:0] set_ok_q;
  logic [8:0] wav_ok_q;
  logic [7:0] set_mem [0:9][0:127];
  logic [7:0] wav_mem [0:8][0:641];
  st_t st_q, st_d;
  logic wav_q, bad_q;
  logic [3:0] sel_q;
  logic [9:0] ptr_q;
  logic [7:0] sum_q;
  logic pf1_q, pf2_q, pf3_q;
  logic [7:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic aw_has_q, w_has_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire wr_go = aw_has_q && w_has_q && !bvalid_q;
  wire rd_go = s_axi_arvalid && !rvalid_q;
  wire [7:0] rd_addr = s_axi_araddr;
  wire wr_ctrl = wr_go && awaddr_q == A_CTRL;
  wire wr_plot = wr_go && awaddr_q == A_PLOT;
  wire wr_cmd = wr_go && awaddr_q == A_CMD;
  wire wr_stat = wr_go && awaddr_q == A_STAT;
  wire wr_data = wr_go && awaddr_q == A_DATA;
  wire wr_map = wr_ctrl | wr_plot | wr_cmd | wr_stat | wr_data;
  wire rd_data = rd_go && rd_addr == A_DATA;
  wire rd_map = rd_addr == A_CTRL || rd_addr == A_PLOT || rd_addr == A_CMD ||
                rd_addr == A_STAT || rd_data || rd_addr == A_FLAG;

  // command fields
  wire op_t cmd_op = op_t'(wdata_q[2:0]);
  wire cmd_wav = wdata_q[CMD_TYPE];
  wire [7:0] cmd_num = wdata_q[CMD_NUM +: 8];
  wire [7:0] cmd_max = cmd_wav ? WAV_MAX : SET_MAX;
  wire cmd_bad = cmd_num[7] || cmd_num > cmd_max;
  wire [3:0] cmd_sel = cmd_num[3:0];
  // an out-of-range number never reaches the valid flags
  wire cmd_valid = !cmd_bad && (cmd_wav ? wav_ok_q[cmd_sel] : set_ok_q[cmd_sel]);
  // store and recall only ever address settings locations
  wire set_bad = cmd_num[7] || cmd_num > SET_MAX;
  wire is_store = wr_cmd && cmd_op == OP_STORE;
  wire store_ok = is_store && !set_bad;
  wire is_recall = wr_cmd && cmd_op == OP_RECALL;
  wire recall_ok = is_recall && !set_bad && set_ok_q[cmd_sel];

  // stream lengths and bytes
  wire [9:0] blk_len = wav_q ? WAV_LEN : SET_LEN;
  wire last_byte = ptr_q == blk_len - 10'h001;
  wire [7:0] in_byte = wdata_q[7:0];
  wire [7:0] mem_byte = wav_q ? wav_mem[sel_q][ptr_q] : set_mem[sel_q][ptr_q[6:0]];
  wire [7:0] out_byte = bad_q ? 8'h00 : mem_byte;
  wire wr_byte = wr_data && st_q == S_WR;
  wire rd_byte = rd_data && st_q == S_RD;
  wire sum_bad = wr_byte && last_byte && sum_q != in_byte;

  // power-off event after synchroniser
  wire pf_rise = pf2_q && !pf3_q;

  // settings snapshot bytes and their internal checksum
  wire [7:0] snap0 = {4'h0, ctrl_q};
  wire [7:0] snap1 = {6'h00, plotter_select_q};
  wire [7:0] snap_sum = snap0 + snap1 + ref_q;

  // plot reference clamp of a signed write value
  wire signed [31:0] ref_in = $signed(wdata_q);
  wire [7:0] ref_clamp = ref_in < 0 ? 8'h00 :
                         ref_in > 32'sd255 ? REF_MAX : ref_in[7:0];

  // ----------------------------------------
  // settings next values
  // ----------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    plotter_select_d = plotter_select_q;
    ref_d = ref_q;
    if (init_q && set_ok_q[0]) begin
      plotter_select_d = set_mem[0][1][1:0];
      ref_d = set_mem[0][2];
    end
    if (wr_ctrl) begin
      ctrl_d = ctrl_t'(wdata_q[3:0]);
    end
    if (wr_plot) begin
      plotter_select_d = wdata_q[1:0];
    end
    if (wr_plot && wdata_q[8]) begin
      ref_d = ref_clamp;
    end
    if (recall_ok) begin
      ctrl_d = ctrl_t'(set_mem[cmd_sel][0][3:0]);
      plotter_select_d = set_mem[cmd_sel][1][1:0];
      ref_d = set_mem[cmd_sel][2];
    end
  end

  // error code and reported register number
  always_comb begin
    err_d = wr_stat ? ERR_NONE : err_q;
    rnum_d = rnum_q;
    if (is_recall && !recall_ok) begin
      err_d = set_bad ? ERR_RANGE : ERR_EMPTY;
    end
    if ((is_store && set_bad) || (wr_cmd && cmd_op == OP_RD_WR && cmd_bad)) begin
      err_d = ERR_RANGE;
    end
    if (sum_bad) begin
      err_d = ERR_SUM;
    end
    if (wr_cmd && cmd_op == OP_RD_RD) begin
      rnum_d = cmd_bad ? NUM_RANGE : !cmd_valid ? NUM_EMPTY : cmd_num;
    end
  end

  // stream state machine
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: begin
        if (wr_cmd && cmd_op == OP_RD_WR && !cmd_bad) begin
          st_d = S_WR;
        end else if (wr_cmd && cmd_op == OP_RD_RD) begin
          st_d = S_RD;
        end
      end
      S_WR: begin
        if (wr_byte && last_byte) begin
          st_d = S_IDLE;
        end
      end
      S_RD: begin
        if (rd_byte && last_byte) begin
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  // plot contents follow switches and display state
  plot_t plot_d;
  wire mac = waveform_block_type_state.macro_buffer_shown;
  always_comb begin
    plot_d.settings = ctrl_q.settings_readout_switch && !mac;
    plot_d.scale_graticule_light_switch = ctrl_q.graticule_light_switch && !mac;
    plot_d.bezel = plot_d.settings && plot_d.scale_graticule_light_switch;
    plot_d.markers_x = waveform_block_type_state.marker_on && waveform_block_type_state.storage_on && !mac;
    plot_d.a_trace = waveform_block_type_state.a_trace_view && !mac;
    plot_d.b_trace = waveform_block_type_state.b_trace_view && !mac;
    plot_d.diff_trace = waveform_block_type_state.difference_trace_view && !mac;
    plot_d.macro_only = mac;
    plot_d.two_colour = plotter_select_q != 2'h0;
  end

  // read data mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_addr == A_CTRL) begin
      rd_word[3:0] = ctrl_q;
    end else if (rd_addr == A_PLOT) begin
      rd_word = {16'h0000, ref_q, 6'h00, plotter_select_q};
    end else if (rd_addr == A_STAT) begin
      rd_word[ST_ERR +: 8] = err_q;
      rd_word[ST_NUM +: 8] = rnum_q;
      rd_word[ST_BUSY +: 2] = st_q;
      rd_word[ST_MACRO +: 4] = MACRO_BYTES;
    end else if (rd_data) begin
      rd_word[7:0] = st_q == S_RD ? out_byte : 8'h00;
    end else if (rd_addr == A_FLAG) begin
      rd_word[8:0] = plot_q;
    end
  end

  // ----------------------------------------
  // AXI4-Lite channel handshakes
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_has_q <= 1'b0;
      w_has_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_has_q) begin
        aw_has_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_has_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_has_q) begin
        w_has_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end else if (wr_go) begin
        w_has_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? 2'h0 : 2'h2; // unmapped: slave error
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel, one read at a time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // settings, status, plot and help registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= ctrl_t'(CTRL_RST);
      plotter_select_q <= PLOTTER_SELECT_RST;
      ref_q <= REF_RST;
      plot_q <= '0;
      err_q <= ERR_NONE;
      rnum_q <= 8'h00;
      init_q <= 1'b1;
      help_q <= 1'b0;
      help_fp_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      plotter_select_q <= plotter_select_d;
      ref_q <= ref_d;
      plot_q <= plot_d;
      err_q <= err_d;
      rnum_q <= rnum_d;
      init_q <= 1'b0;
      help_q <= wr_cmd && cmd_op == OP_HELP;
      if (wr_cmd && cmd_op == OP_HELP) begin
        help_fp_q <= wdata_q[CMD_FP];
      end
    end
  end

  // stream pointer, checksum and validity flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      wav_q <= 1'b0;
      bad_q <= 1'b0;
      sel_q <= 4'h0;
      ptr_q <= 10'h000;
      sum_q <= 8'h00;
      set_ok_q <= '0;
      wav_ok_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_q == S_IDLE && st_d != S_IDLE) begin
        wav_q <= cmd_wav;
        sel_q <= cmd_sel;
        bad_q <= cmd_bad || !cmd_valid;
        ptr_q <= 10'h000;
        sum_q <= 8'h00;
      end else if (wr_byte || rd_byte) begin
        ptr_q <= ptr_q + 10'h001;
        sum_q <= sum_q + in_byte;
      end
      if (wr_byte && ptr_q == 10'h000) begin
        if (wav_q) wav_ok_q[sel_q] <= 1'b0;
        else set_ok_q[sel_q] <= 1'b0;
      end
      if (wr_byte && last_byte && !sum_bad) begin
        if (wav_q) wav_ok_q[sel_q] <= 1'b1;
        else set_ok_q[sel_q] <= 1'b1;
      end
      if (store_ok) begin
        set_ok_q[cmd_sel] <= 1'b1;
      end
      if (pf_rise) begin
        set_ok_q[0] <= 1'b1;
      end
    end
  end

  // power-fail synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pf1_q <= 1'b0;
      pf2_q <= 1'b0;
      pf3_q <= 1'b0;
    end else begin
      pf1_q <= power_fail;
      pf2_q <= pf1_q;
      pf3_q <= pf2_q;
    end
  end

  // ----------------------------------------
  // register memories, not reset
  // ----------------------------------------
  wire snap_go = store_ok || pf_rise;
  wire [3:0] snap_sel = pf_rise ? 4'h0 : cmd_sel;
  always_ff @(posedge clk) begin
    if (snap_go) begin
      for (int i = 0; i < 128; i++) begin
        set_mem[snap_sel][i] <= 8'h00;
      end
      set_mem[snap_sel][0] <= snap0;
      set_mem[snap_sel][1] <= snap1;
      set_mem[snap_sel][2] <= ref_q;
      set_mem[snap_sel][127] <= snap_sum;
    end else if (wr_byte && wav_q) begin
      wav_mem[sel_q][ptr_q] <= in_byte;
    end else if (wr_byte) begin
      set_mem[sel_q][ptr_q[6:0]] <= in_byte;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !aw_has_q;
  assign s_axi_wready = !w_has_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ctrl = ctrl_q;
  assign plotter_select = plotter_select_q;
  assign difference_plot_reference = ref_q;
  assign plot_content = plot_q;
  assign help_req = help_q;
  assign help_front_panel = help_fp_q;
endmodule

// file: tb/axi_host.sv
// register bus host model that stands in for the remote controller
`timescale 1ns/10ps
module axi_host (
  input wire logic clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
  end
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a; // released lines stop showing the old value
      end
      if (!dd && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    // a slow response acceptor makes the slave hold its answer
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read: address held until taken, data taken with rvalid and rready
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat ($urandom_range(2)) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: tb/dsr_cmd_sva.sv
// concurrent checks on the display and settings command block ports
`timescale 1ns/10ps
module dsr_cmd_sva
  import dsr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dsr_pkg::waveform_block_type_t waveform_block_type_state,
  input wire dsr_pkg::ctrl_t ctrl,
  input wire logic [1:0] plotter_select,
  input wire dsr_pkg::plot_t plot_content,
  input wire logic help_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // plot is normal output only while the macro buffer is hidden
  wire logic nm = !waveform_block_type_state.macro_buffer_shown;
  a_plot_readout: assert property ($past(rstn, 2) |->
    plot_content.settings == $past(ctrl.settings_readout_switch && nm) &&
    plot_content.bezel == $past(ctrl.settings_readout_switch && ctrl.graticule_light_switch && nm)
    && plot_content.scale_graticule_light_switch == $past(ctrl.graticule_light_switch && nm))
    else $error("plot readout wrong");
  a_plot_markers: assert property ($past(rstn, 2) |->
    plot_content.markers_x == $past(waveform_block_type_state.marker_on && waveform_block_type_state.storage_on && nm))
    else $error("plot markers wrong");
  a_plot_traces: assert property ($past(rstn, 2) |->
    {plot_content.a_trace, plot_content.b_trace, plot_content.diff_trace} == $past(
    {waveform_block_type_state.a_trace_view, waveform_block_type_state.b_trace_view,
    waveform_block_type_state.difference_trace_view} & {3{nm}}))
    else $error("plot traces wrong");
  a_plot_macro: assert property ($past(rstn, 2) && $past(!nm) |->
    plot_content[7:0] == 8'h80) else $error("macro plot not alone");
  a_plot_pens: assert property ($past(rstn, 2) && $past(nm) |->
    plot_content.two_colour == ($past(plotter_select) != 2'h0)) else $error("pen colour wrong");
  a_help_pulse: assert property (help_req |=> !help_req) else $error("help pulse long");
  a_ctrl_reset: assert property ($rose(rstn) |-> ctrl == CTRL_RST)
    else $error("switch reset wrong");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_help: cover property (help_req);
  c_macro: cover property (!nm ##1 !nm);
endmodule

// file: tb/dsr_cmd_test.sv
// self-checking bench for the display and settings command block
`timescale 1ns/10ps
module dsr_cmd_test;
  import dsr_pkg::*;
  logic clk, rstn, power_fail, help_req, help_front_panel;
  logic [7:0] s_axi_awaddr, s_axi_araddr, difference_plot_reference;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, plotter_select, resp, p;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  waveform_block_type_t waveform_block_type_state;
  ctrl_t ctrl, cv;
  plot_t plot_content;
  int err_count = 0, samples_checked = 0, help_n = 0;
  logic [7:0] blk [642];
  logic [11:0] bad [4] = '{12'h10A, 12'h20A, 12'h30A, 12'hB09}; // {wave, op, number}

  dsr_cmd dut (.*);
  axi_host h (.*);

  // 20 MHz clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // count help request pulses
  always @(posedge clk) if (help_req === 1'b1) help_n <= help_n + 1;
  // watchdog
  initial begin
    #3000000;
    err_count++;
    end_of_test();
  end

  function automatic plot_t exp_plot(ctrl_t c, waveform_block_type_t s, logic [1:0] pt);
    plot_t e;
    e = '0;
    e.macro_only = s.macro_buffer_shown;
    if (!s.macro_buffer_shown) begin
      e.settings = c.settings_readout_switch;
      e.scale_graticule_light_switch = c.graticule_light_switch;
      e.bezel = c.settings_readout_switch & c.graticule_light_switch;
      e.markers_x = s.marker_on & s.storage_on;
      {e.a_trace, e.b_trace} = {s.a_trace_view, s.b_trace_view};
      e.diff_trace = s.difference_trace_view;
      e.two_colour = pt != 2'h0;
    end
    return e;
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      err_count++;
    end
  endtask
  task automatic w(logic [7:0] a, logic [31:0] v);
    h.wr(a, v, resp);
    chk("write resp", resp, 0);
  endtask
  task automatic rc(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    h.rd(a, d, resp);
    chk(n, d & m, e);
  endtask
  task automatic cmd(logic [2:0] op, logic [1:0] f, logic [7:0] n);
    w(A_CMD, {16'h0, n, 3'h0, f, op});
  endtask
  // read the error code, then clear it
  task automatic err(logic [7:0] e);
    rc("error", A_STAT, 32'hFF, {24'h0, e});
    w(A_STAT, 0);
  endtask
  // settings block with its byte sum appended, optionally corrupted
  task automatic mk(logic [7:0] c, logic [7:0] pt, logic [7:0] r, logic [7:0] x);
    logic [7:0] s;
    s = 0;
    for (int i = 0; i < 127; i++) begin
      blk[i] = i == 0 ? c : i == 1 ? pt : i == 2 ? r : 8'($urandom);
      s += blk[i];
    end
    blk[127] = s + x;
  endtask
  task automatic qry(logic wv, logic [7:0] n, logic [7:0] en);
    cmd(3'h4, {1'b0, wv}, n);
    rc("number", A_STAT, 32'h3FF00, {14'h0, 2'h3, en, 8'h0});
    for (int i = 0; i < (wv ? WAV_LEN : SET_LEN); i++) begin
      rc("data", A_DATA, 32'hFF, {24'h0, blk[i]});
    end
    rc("stream", A_STAT, 32'h30000, 0);
  endtask
  task automatic put(logic wv, logic [7:0] n);
    cmd(3'h3, {1'b0, wv}, n);
    for (int i = 0; i < SET_LEN; i++) w(A_DATA, {24'h0, blk[i]});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 0;
    power_fail = 0;
    waveform_block_type_state = '0;
    d = $urandom(32'h600F);
    repeat (16) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    chk("ctrl", ctrl, CTRL_RST);
    rc("plot reg", A_PLOT, 32'hFF03, {16'h0, REF_RST, 8'h0});
    rc("macro", A_STAT, 32'hF000000, {4'h0, MACRO_BYTES, 24'h0});
    h.rd(8'h20, d, resp);
    chk("unmapped", resp, 2);
    h.wr(8'h24, 0, resp);
    chk("unmapped write", resp, 2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      w(A_PLOT, i);
      chk("plotter", plotter_select, i);
      rc("plot reg", A_PLOT, 32'hFF03, {16'h0, REF_RST, 6'h0, 2'(i)});
    end
    w(A_PLOT, 32'hFFFFFF00);
    chk("ref", difference_plot_reference, 0);
    w(A_PLOT, 32'h7FFF0100);
    chk("ref", difference_plot_reference, REF_MAX);
    $display("test plotter done");
    repeat (24) begin
      waveform_block_type_state <= 6'($urandom);
      cv = 4'($urandom);
      p = 2'($urandom);
      w(A_CTRL, cv);
      w(A_PLOT, p);
      rc("ctrl reg", A_CTRL, 32'hF, cv);
      rc("flag", A_FLAG, {23'h0, !waveform_block_type_state.macro_buffer_shown, 8'hFF},
        exp_plot(cv, waveform_block_type_state, p));
    end
    $display("test plot done");
    w(A_CTRL, 4'h6);
    cmd(3'h1, 0, 3);
    w(A_CTRL, 4'h9);
    cmd(3'h2, 0, 3);
    chk("recall", ctrl, 4'h6);
    cmd(3'h2, 0, 7);
    err(ERR_EMPTY);
    foreach (bad[i]) begin
      cmd(bad[i][10:8], {1'b0, bad[i][11]}, bad[i][7:0]);
      err(ERR_RANGE);
    end
    $display("test store done");
    foreach (blk[i]) blk[i] = 0;
    qry(0, 12, NUM_RANGE);
    qry(1, 9, NUM_RANGE);
    qry(1, 3, NUM_EMPTY);
    mk(8'h6, 8'h2, 8'h40, 0);
    put(0, 4);
    err(ERR_NONE);
    qry(0, 4, 8'h4);
    cmd(3'h2, 0, 4);
    chk("recall", {ctrl, plotter_select}, 6'h1A);
    mk(8'h3, 8'h1, 8'h10, 1);
    put(0, 5);
    err(ERR_SUM);
    cmd(3'h2, 0, 5);
    err(ERR_EMPTY);
    $display("test register data done");
    for (int f = 1; f >= 0; f--) begin
      cmd(3'h5, {f[0], 1'b0}, 0);
      @(posedge clk);
      chk("help arg", help_front_panel, f);
      chk("help count", help_n, 2 - f);
    end
    $display("test help done");
    w(A_CTRL, 4'hA);
    power_fail <= 1;
    repeat (6) @(posedge clk);
    power_fail <= 0;
    cmd(3'h4, 0, 0);
    rc("saved", A_STAT, 32'hFF00, 0);
    rc("saved", A_DATA, 32'hFF, 4'hA);
    $display("test power off done");
    end_of_test();
  end
endmodule

bind dsr_cmd dsr_cmd_sva sva (.*);
